// *** hw/modem_line_status.sv ***
/*
 * Modem status, scratch byte and reset state of one UART channel, with an
 * APB register slave, sticky event flags and one level interrupt.
 * Assumes the transmitter reports a character in progress on tx_busy and
 * obeys tx_halt only between characters; modem pins are asynchronous.
 */
`timescale 1ns/1ps

module modem_line_status
	import modem_status_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire modem_pins_t modem_pins,
	input  wire logic        tx_line,
	input  wire logic        tx_busy,
	input  wire logic        rx_ready_in,
	input  wire logic        tx_ready_in,
	input  wire logic [4:0]  line_flags,
	output modem_outs_t      modem_outs,
	output logic             receive_ready_out,
	output logic             transmit_ready_out,
	output logic             tx_halt,
	output logic             irq
);

	// ************************************************************
	// Address decode
	// ************************************************************
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	logic access;
	logic wr;
	logic rd;
	logic mapped;

	assign access = psel & penable;
	assign wr     = access & pwrite;
	assign rd     = access & ~pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		mapped = hit(paddr, OFF_INT_ENABLE) | hit(paddr, OFF_INT_STATUS) |
			hit(paddr, OFF_LINE_CTRL) | hit(paddr, OFF_MODEM_CTRL) |
			hit(paddr, OFF_LINE_STATUS) | hit(paddr, OFF_MODEM_STAT) |
			hit(paddr, OFF_SCRATCH) | hit(paddr, OFF_EVT_STATUS) |
			hit(paddr, OFF_EVT_MASK) | hit(paddr, OFF_FIFO_CTRL);
	end

	assign pslverr = access & ~mapped;

	// ************************************************************
	// Control registers
	// ************************************************************
	logic [7:0] interrupt_enable_reg;
	logic [7:0] line_control_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] fifo_control_reg;
	logic [7:0] scratch_byte;
	logic [1:0] evt_mask;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			interrupt_enable_reg <= RST_INT_ENABLE;
			line_control_reg     <= RST_LINE_CTRL;
			modem_control_reg    <= RST_MODEM_CTRL;
			fifo_control_reg     <= RST_FIFO_CTRL;
		end
		else if (wr)
		begin
			if (hit(paddr, OFF_INT_ENABLE))
				interrupt_enable_reg <= pwdata[7:0];
			if (hit(paddr, OFF_LINE_CTRL))
				line_control_reg <= pwdata[7:0];
			if (hit(paddr, OFF_MODEM_CTRL))
				modem_control_reg <= pwdata[7:0];
			// Same offset as interrupt status; writes land here
			if (hit(paddr, OFF_FIFO_CTRL))
				fifo_control_reg <= pwdata[7:0];
		end
	end

	// Storage only, nothing reads it but the bus
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			scratch_byte <= RST_SCRATCH;
		else if (wr && hit(paddr, OFF_SCRATCH))
			scratch_byte <= pwdata[7:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			evt_mask <= RST_EVT;
		else if (wr && hit(paddr, OFF_EVT_MASK))
			evt_mask <= pwdata[1:0];
	end

	// ************************************************************
	// Modem input synchroniser
	// ************************************************************
	// Not reset, so the status nibble keeps tracking pins during reset
	modem_pins_t pins_meta;
	modem_pins_t pins_sync;

	always_ff @(posedge clk_sys)
	begin
		pins_meta <= modem_pins;
		pins_sync <= pins_meta;
	end

	// ************************************************************
	// Current modem status nibble
	// ************************************************************
	logic       loop_mode;
	logic [3:0] status_now;

	assign loop_mode = modem_control_reg[MC_LOOP];

	always_comb
	begin
		if (loop_mode)
		begin
			status_now[3] = modem_control_reg[MC_OUT2];
			status_now[2] = modem_control_reg[MC_OUT1];
			status_now[1] = modem_control_reg[MC_DTR];
			status_now[0] = modem_control_reg[MC_RTS];
		end
		else
		begin
			status_now[3] = ~pins_sync.cd_n;
			status_now[2] = ~pins_sync.ri_n;
			status_now[1] = ~pins_sync.dsr_n;
			status_now[0] = ~pins_sync.cts_n;
		end
	end

	// ************************************************************
	// Change detection
	// ************************************************************
	logic [3:0] status_prev;
	logic [3:0] change_now;
	logic [3:0] delta;
	logic       rd_modem_stat;

	assign rd_modem_stat = rd & hit(paddr, OFF_MODEM_STAT);

	// Synchroniser is not cleared by reset, so edges are ignored until
	// both stages and the previous copy hold real pin levels
	logic [1:0] primed;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			primed <= 2'b00;
		else
			primed <= {primed[0], 1'b1};
	end

	// Previous value tracks in reset so release brings no false change
	always_ff @(posedge clk_sys)
	begin
		status_prev <= status_now;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_delta
			if (g == 2)
			begin : g_ring
				// Ring reports the rising edge only
				assign change_now[g] = primed[1] & status_now[g] & ~status_prev[g];
			end
			else
			begin : g_level
				assign change_now[g] = primed[1] & (status_now[g] ^ status_prev[g]);
			end

			// Set beats the read clear so no edge is lost
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					delta[g] <= 1'b0;
				else if (change_now[g])
					delta[g] <= 1'b1;
				else if (rd_modem_stat)
					delta[g] <= 1'b0;
			end
		end
	endgenerate

	logic [7:0] modem_line_status;
	assign modem_line_status = {status_now, delta};

	// ************************************************************
	// Interrupt identification
	// ************************************************************
	logic       modem_pending;
	logic [7:0] interrupt_status_reg;

	assign modem_pending = (|delta) & interrupt_enable_reg[IE_MODEM];

	// Modem status has the lowest priority code (all zero) and bit 0 low
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			interrupt_status_reg <= RST_INT_STATUS;
		else
			interrupt_status_reg <= {7'h00, ~modem_pending};
	end

	// ************************************************************
	// Line status
	// ************************************************************
	// Receive side flags come from the receiver; holding empty follows
	// tx_ready_in and shift empty sits high while tx_busy is low
	logic [7:0] line_status_reg;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			line_status_reg <= RST_LINE_STATUS;
		else
			line_status_reg <= {1'b0, ~tx_busy, tx_ready_in, line_flags};
	end

	// ************************************************************
	// Clear-to-send flow control
	// ************************************************************
	// Decision is taken only between characters so a started one finishes
	logic halt_req;
	logic halt_rise;

	assign halt_req = modem_control_reg[MC_FLOW] & pins_sync.cts_n;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			tx_halt <= 1'b0;
		else if (!tx_busy)
			tx_halt <= halt_req;
	end

	assign halt_rise = ~tx_busy & halt_req & ~tx_halt;

	// ************************************************************
	// Event flags and interrupt
	// ************************************************************
	logic [1:0] evt_set;
	logic [1:0] evt_status;
	logic       rd_evt;

	assign evt_set[EV_MODEM] = |change_now;
	assign evt_set[EV_HALT]  = halt_rise;
	assign rd_evt            = rd & hit(paddr, OFF_EVT_STATUS);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			evt_status <= RST_EVT;
		else
			evt_status <= evt_set | (evt_status & {2{~rd_evt}});
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(evt_status & evt_mask);
	end

	// ************************************************************
	// Pin outputs
	// ************************************************************
	// Loop-back keeps the line idle and the handshake pins inactive
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			modem_outs.serial_tx <= 1'b1;
			modem_outs.rts_n     <= 1'b1;
			modem_outs.dtr_n     <= 1'b1;
			receive_ready_out    <= 1'b1;
			transmit_ready_out   <= 1'b0;
		end
		else
		begin
			modem_outs.serial_tx <= loop_mode | tx_line;
			modem_outs.rts_n     <= loop_mode | ~modem_control_reg[MC_RTS];
			modem_outs.dtr_n     <= loop_mode | ~modem_control_reg[MC_DTR];
			receive_ready_out    <= rx_ready_in;
			transmit_ready_out   <= tx_ready_in;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd)
		begin
			if (hit(paddr, OFF_INT_ENABLE))
				prdata[7:0] = interrupt_enable_reg;
			else if (hit(paddr, OFF_INT_STATUS))
				prdata[7:0] = interrupt_status_reg;
			else if (hit(paddr, OFF_LINE_CTRL))
				prdata[7:0] = line_control_reg;
			else if (hit(paddr, OFF_MODEM_CTRL))
				prdata[7:0] = modem_control_reg;
			else if (hit(paddr, OFF_LINE_STATUS))
				prdata[7:0] = line_status_reg;
			else if (hit(paddr, OFF_MODEM_STAT))
				prdata[7:0] = modem_line_status;
			else if (hit(paddr, OFF_SCRATCH))
				prdata[7:0] = scratch_byte;
			else if (hit(paddr, OFF_EVT_STATUS))
				prdata[1:0] = evt_status;
			else if (hit(paddr, OFF_EVT_MASK))
				prdata[1:0] = evt_mask;
		end
	end

	// fifo_control_reg is stored but drives no port or logic; it is
	// write-only here because its offset reads interrupt status
	logic unused_fifo;
	assign unused_fifo = ^fifo_control_reg;

endmodule : modem_line_status

// *** hw/modem_status_pkg.sv ***
/*
 * Constants and carrier types for the modem status, scratch and reset block
 * of one UART channel.
 * Assumes an APB master with 32-bit data and byte addresses on word bounds.
 */
package modem_status_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFF_INT_ENABLE  = 8'h04;
	localparam logic [7:0] OFF_INT_STATUS  = 8'h08;
	localparam logic [7:0] OFF_FIFO_CTRL   = 8'h08;
	localparam logic [7:0] OFF_LINE_CTRL   = 8'h0c;
	localparam logic [7:0] OFF_MODEM_CTRL  = 8'h10;
	localparam logic [7:0] OFF_LINE_STATUS = 8'h14;
	localparam logic [7:0] OFF_MODEM_STAT  = 8'h18;
	localparam logic [7:0] OFF_SCRATCH     = 8'h1c;
	localparam logic [7:0] OFF_EVT_STATUS  = 8'h20;
	localparam logic [7:0] OFF_EVT_MASK    = 8'h24;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
	localparam logic [7:0] RST_INT_STATUS  = 8'h01;
	localparam logic [7:0] RST_LINE_CTRL   = 8'h00;
	localparam logic [7:0] RST_MODEM_CTRL  = 8'h00;
	localparam logic [7:0] RST_FIFO_CTRL   = 8'h00;
	localparam logic [7:0] RST_LINE_STATUS = 8'h60;
	localparam logic [7:0] RST_SCRATCH     = 8'h00;
	localparam logic [1:0] RST_EVT         = 2'h0;

	// ************************************************************
	// Modem control register fields
	// ************************************************************
	localparam int MC_DTR  = 0;
	localparam int MC_RTS  = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_OUT2 = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_FLOW = 5;

	// Interrupt enable bit for modem status changes
	localparam int IE_MODEM = 3;

	// Event status fields
	localparam int EV_MODEM = 0;
	localparam int EV_HALT  = 1;

	// Active-low modem inputs, one bit each
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} modem_pins_t;

	// Modem outputs of the channel, pin levels
	typedef struct packed {
		logic serial_tx;
		logic rts_n;
		logic dtr_n;
	} modem_outs_t;

endpackage : modem_status_pkg

// *** test/modem_line_status_properties.sv ***
/*
 * Port checker of the modem status block.
 * Assumes it is bound into modem_line_status and sees its ports only.
 */
`timescale 1ns/1ps

module modem_line_status_checker
	import modem_status_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire modem_pins_t modem_pins,
	input wire logic        tx_busy,
	input wire modem_outs_t modem_outs,
	input wire logic        receive_ready_out,
	input wire logic        transmit_ready_out,
	input wire logic        tx_halt
);
	logic [7:0] mc_shadow;
	logic [7:0] scr_shadow;
	logic [3:0] quiet_cnt;
	logic       fresh;
	logic       acc;
	logic       halt_want;
	assign acc = psel && penable;
	assign halt_want = mc_shadow[5] & modem_pins.cts_n;

	// ************************************************************
	// Shadow state
	// ************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mc_shadow <= 8'h00;
			scr_shadow <= 8'h00;
			fresh <= 1'b1;
		end
		else if (acc && pwrite)
		begin
			fresh <= 1'b0;
			if (paddr == OFF_MODEM_CTRL)
				mc_shadow <= pwdata[7:0];
			if (paddr == OFF_SCRATCH)
				scr_shadow <= pwdata[7:0];
		end
	end

	// Quiet means no pin move and no control write: no new change bit can be set
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || modem_pins != $past(modem_pins) || (acc && pwrite && paddr == OFF_MODEM_CTRL))
			quiet_cnt <= 4'h0;
		else if (quiet_cnt != 4'hf)
			quiet_cnt <= quiet_cnt + 4'h1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence rd_quiet;
		acc && !pwrite && paddr == OFF_MODEM_STAT && !mc_shadow[4] && quiet_cnt >= 4'h6;
	endsequence

	a_read_clears: assert property (rd_quiet ##3 rd_quiet |-> prdata[3:0] == 4'h0)
		else $error("change bits survive a read");
	a_pin_status: assert property (rd_quiet |-> prdata[7:4] == ~$past(modem_pins))
		else $error("status nibble differs from pins");
	a_loop_status: assert property (acc && !pwrite && paddr == OFF_MODEM_STAT && mc_shadow[4] |->
		prdata[7:4] == {mc_shadow[3], mc_shadow[2], mc_shadow[0], mc_shadow[1]})
		else $error("loop status differs from control");
	a_scratch_echo: assert property (acc && !pwrite && paddr == OFF_SCRATCH |-> prdata == {24'h0, scr_shadow})
		else $error("scratch read differs");
	a_reset_regs: assert property (acc && !pwrite && fresh && (paddr == OFF_INT_ENABLE ||
		paddr == OFF_LINE_CTRL || paddr == OFF_MODEM_CTRL) |-> prdata == 32'h0)
		else $error("control register not cleared");
	a_reset_outs: assert property ($fell(sys_rst) |->
		modem_outs == 3'b111 && receive_ready_out && !transmit_ready_out)
		else $error("reset pin levels wrong");
	a_halt_frozen: assert property (tx_busy |=> $stable(tx_halt))
		else $error("halt moved mid character");
	a_halt_cts: assert property (!tx_busy && quiet_cnt >= 4'h6 |=> tx_halt == $past(halt_want, 2))
		else $error("halt differs from flow state");
endmodule : modem_line_status_checker

bind modem_line_status modem_line_status_checker i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .modem_pins(modem_pins),
	.tx_busy(tx_busy), .modem_outs(modem_outs), .receive_ready_out(receive_ready_out),
	.transmit_ready_out(transmit_ready_out), .tx_halt(tx_halt));

// *** test/modem_peer.sv ***
/*
 * Model of the modem at the far side: drives the four active-low lines.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
`timescale 1ns/1ps

module modem_peer
	import modem_status_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [3:0]  line_want,
	output modem_pins_t      modem_pins
);
	// ************************************************************
	// Line drive
	// ************************************************************
	// Lines move on the clock edge; the block's own synchroniser absorbs them
	always_ff @(posedge clk_sys)
		modem_pins <= line_want;
endmodule : modem_peer

// *** test/test_modem_line_status.sv ***
/*
 * Self-checking bench of the modem status block over APB.
 * Assumes modem_peer drives the modem lines and the checker is bound in.
 */
`timescale 1ns/1ps

module test_modem_line_status;
	import modem_status_pkg::*;
	logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, last_err;
	logic        tx_line, tx_busy, rx_ready_in, tx_ready_in, receive_ready_out, transmit_ready_out, tx_halt, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [4:0]  line_flags;
	logic [3:0]  line_want;
	modem_pins_t modem_pins;
	modem_outs_t modem_outs;
	int          bad_count, compares, cycles;

	modem_peer i_peer (.clk_sys(clk_sys), .line_want(line_want), .modem_pins(modem_pins));
	modem_line_status i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.modem_pins(modem_pins), .tx_line(tx_line), .tx_busy(tx_busy), .rx_ready_in(rx_ready_in),
		.tx_ready_in(tx_ready_in), .line_flags(line_flags), .modem_outs(modem_outs),
		.receive_ready_out(receive_ready_out), .transmit_ready_out(transmit_ready_out), .tx_halt(tx_halt), .irq(irq));

	// ************************************************************
	// Clock, timeout and report
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic wrap_up;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk

	// ************************************************************
	// APB master
	// ************************************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(exp, q);
	endtask : rd_chk

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset_regs;
		rd_chk(OFF_INT_ENABLE, 32'h0);
		rd_chk(OFF_LINE_CTRL, 32'h0);
		rd_chk(OFF_MODEM_CTRL, 32'h0);
		rd_chk(OFF_INT_STATUS, 32'h1);
		rd_chk(OFF_LINE_STATUS, 32'h60);
		rd_chk(OFF_MODEM_STAT, 32'ha0);
	endtask : t_reset_regs

	task automatic t_scratch;
		apb(1'b1, OFF_SCRATCH, 32'h1234_56a5);
		rd_chk(OFF_SCRATCH, 32'ha5);
		rd_chk(OFF_MODEM_STAT, 32'ha0);
		apb(1'b1, 8'h00, 32'hff);
		chk(32'h1, {31'h0, last_err});
		rd_chk(OFF_SCRATCH, 32'ha5);
	endtask : t_scratch

	task automatic t_pins;
		apb(1'b1, OFF_EVT_MASK, 32'h1);
		apb(1'b1, OFF_INT_ENABLE, 32'h8);
		line_want <= 4'b1010;
		repeat (8) @(posedge clk_sys);
		chk(32'h1, {31'h0, irq});
		rd_chk(OFF_INT_STATUS, 32'h0);
		rd_chk(OFF_MODEM_STAT, 32'h5f);
		rd_chk(OFF_MODEM_STAT, 32'h50);
		rd_chk(OFF_EVT_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(32'h0, {31'h0, irq});
		line_want <= 4'b1110;
		repeat (8) @(posedge clk_sys);
		rd_chk(OFF_MODEM_STAT, 32'h10);
		line_want <= 4'b0101;
		repeat (8) @(posedge clk_sys);
		rd_chk(OFF_MODEM_STAT, 32'hab);
		// Change lands on the read's access edge and must survive the clear
		line_want <= 4'b0111;
		repeat (2) @(posedge clk_sys);
		rd_chk(OFF_MODEM_STAT, 32'h80);
		rd_chk(OFF_MODEM_STAT, 32'h82);
		rd_chk(OFF_EVT_STATUS, 32'h1);
	endtask : t_pins

	task automatic t_loop;
		apb(1'b1, OFF_MODEM_CTRL, 32'h1f);
		rd_chk(OFF_LINE_CTRL, 32'h0);
		chk(32'h7, 32'(modem_outs));
		apb(1'b0, OFF_MODEM_STAT, 32'h0);
		chk(32'hf, {28'h0, q[7:4]});
		apb(1'b1, OFF_MODEM_CTRL, 32'h15);
		apb(1'b0, OFF_MODEM_STAT, 32'h0);
		chk(32'h6, {28'h0, q[7:4]});
		apb(1'b1, OFF_MODEM_CTRL, 32'h03);
		repeat (2) @(posedge clk_sys);
		chk(32'h4, 32'(modem_outs));
	endtask : t_loop

	task automatic t_flow;
		tx_busy <= 1'b1;
		apb(1'b1, OFF_MODEM_CTRL, 32'h20);
		repeat (4) @(posedge clk_sys);
		apb(1'b0, OFF_EVT_STATUS, 32'h0);
		chk(32'h1, q);
		chk(32'h0, {31'h0, tx_halt});
		tx_busy <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(32'h1, {31'h0, tx_halt});
		rd_chk(OFF_EVT_STATUS, 32'h2);
	endtask : t_flow

	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		line_want = 4'h5;
		tx_line = 1'b1;
		tx_busy = 1'b0;
		rx_ready_in = 1'b1;
		tx_ready_in = 1'b1;
		line_flags = 5'h00;
		repeat (2) @(posedge clk_sys);
		chk(32'h7, 32'(modem_outs));
		chk(32'h2, {30'h0, receive_ready_out, transmit_ready_out});
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_reset_regs();
		t_scratch();
		t_pins();
		t_loop();
		t_flow();
		wrap_up();
	end
endmodule : test_modem_line_status
